// ---- core/ipc_defines.vh ----
// register map, field positions and reset values of the interrupt control
`ifndef IPC_DEFINES_VH
`define IPC_DEFINES_VH

// ----------------------------------------------------------------
// register word addresses
// ----------------------------------------------------------------
`define IPC_ADR_W0 10'h000
`define IPC_ADR_W1 10'h001
`define IPC_ADR_TBC 10'h002
`define IPC_ADR_TDAD 10'h003
`define IPC_ADR_EXHI 10'h022
`define IPC_ADR_SEREX 10'h023
`define IPC_ADR_ESEL1 10'h026
`define IPC_ADR_ESEL2 10'h027

// ----------------------------------------------------------------
// bit positions inside a four-bit control word
// ----------------------------------------------------------------
`define IPC_IE_BIT 0
`define IPC_LO_FLAG 0
`define IPC_LO_MASK 1
`define IPC_HI_FLAG 2
`define IPC_HI_MASK 3

// ----------------------------------------------------------------
// flag / mask slot indexes
// ----------------------------------------------------------------
`define IPC_I_PIN0 0
`define IPC_I_PIN1 1
`define IPC_I_TMRA 2
`define IPC_I_TMRB 3
`define IPC_I_PIN2 4
`define IPC_I_TMRC 5
`define IPC_I_PIN3 6
`define IPC_I_TMRD 7
`define IPC_I_PIN4 8
`define IPC_I_ADC 9
`define IPC_I_SER 10

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define IPC_RST_FLAGS 11'h000
`define IPC_RST_MASKS 11'h7ff
`define IPC_RST_ESEL 4'h0
`define IPC_RST_IE 1'b0

// ----------------------------------------------------------------
// edge select codes and priority slot codes
// ----------------------------------------------------------------
`define IPC_EDGE_NONE 2'h0
`define IPC_EDGE_FALL 2'h1
`define IPC_EDGE_RISE 2'h2
`define IPC_EDGE_BOTH 2'h3
`define IPC_SLOT_NONE 3'h0

`endif

// ---- core/ipc_top.v ----
// interrupt priority control: flags, masks, edge select, priority pick
//
// Functional notes
// - with enable set, only the highest unmasked requesting slot is chosen.
// - global enable at word0 bit0; zero blocks servicing, one permits.
// - enable cleared on accept, set again by return from interrupt.
// - pin zero and one flags set on falling edge of the pin.
// - pin two to four flags set on edge picked per pin.
// - edge code 00 none, 01 falling, 10 rising, 11 both.
// - edge select one: write-only, reset 0, pin2 bits1:0, pin3 bits3:2.
// - edge select two: write-only, reset 0, pin4 bits1:0, event bits3:2.
// - external mask zero passes request, one blocks; flag may stay set.
// - timer A flag at word1 bit2 set by timer A overflow.
// - timer A mask at word1 bit3 blocks when one.
// - timer B flag word2 bit0 on overflow, mask bit1.
// - timer C flag word2 bit2 on overflow, mask bit3.
// - timer D flag word3 bit0 on overflow or capture edge, mask bit1.
// - serial flag word5 bit2 on transfer done or suspend, mask bit3.
// - converter flag word3 bit2 on conversion done, mask bit3.
// - request is flag one and mask zero, serviced only with enable.
// - software writes can only clear flags, never set them.
// - reset clears enable and flags, sets all masks.
// - enable clears in second cycle after acknowledge.
`timescale 1ns/1ps

`include "ipc_defines.vh"

module ipc_top #(
	parameter ADDR_W = 10
) (
	input wire clk_in,
	input wire rst_b_in,
	input wire [ADDR_W-1:0] addr_in,
	input wire wr_en_in,
	input wire [3:0] wr_bits_in,
	input wire [3:0] wr_data_in,
	input wire rd_en_in,
	output reg [3:0] rd_data_out,
	input wire ext_irq_pin_zero_b_in,
	input wire ext_irq_pin_one_b_in,
	input wire ext_irq_pin_two_in,
	input wire ext_irq_pin_three_in,
	input wire ext_irq_pin_four_in,
	input wire timer_d_event_pin_in,
	input wire tmr_d_capture_mode_in,
	input wire tmr_a_ovf_in,
	input wire tmr_b_ovf_in,
	input wire tmr_c_ovf_in,
	input wire tmr_d_ovf_in,
	input wire serial_done_in,
	input wire converter_done_in,
	input wire int_ack_in,
	input wire return_from_interrupt_in,
	output reg int_req_out,
	output reg [2:0] int_slot_out,
	output reg global_int_enable_out,
	output reg timer_d_event_edge_out
);

	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	reg [1:0] rst_sync_q;
	wire rst_b;

	always @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in)
			rst_sync_q <= 2'h0;
		else
			rst_sync_q <= {rst_sync_q[0], 1'b1};
	end

	assign rst_b = rst_sync_q[1];

	// ----------------------------------------------------------------
	// functions
	// ----------------------------------------------------------------
	function edge_hit;
		input [1:0] sel;
		input prev;
		input cur;
		begin
			case (sel)
				`IPC_EDGE_FALL: edge_hit = prev & ~cur;
				`IPC_EDGE_RISE: edge_hit = ~prev & cur;
				`IPC_EDGE_BOTH: edge_hit = prev ^ cur;
				default: edge_hit = 1'b0;
			endcase
		end
	endfunction

	// software may only drop a flag: bit enabled and written zero
	function sw_clr;
		input [3:0] bits;
		input [3:0] dat;
		input integer pos;
		begin
			sw_clr = bits[pos] & ~dat[pos];
		end
	endfunction

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	// order: pin0, pin1, pin2, pin3, pin4, event
	wire [5:0] pin_raw;
	reg [5:0] pin_s1_q;
	reg [5:0] pin_s2_q;
	reg [5:0] pin_s3_q;
	reg [2:0] prime_q;
	wire sync_ok;

	assign pin_raw = {timer_d_event_pin_in, ext_irq_pin_four_in,
		ext_irq_pin_three_in, ext_irq_pin_two_in,
		ext_irq_pin_one_b_in, ext_irq_pin_zero_b_in};

	always @(posedge clk_in or negedge rst_b) begin
		if (!rst_b) begin
			pin_s1_q <= 6'h3f;
			pin_s2_q <= 6'h3f;
			pin_s3_q <= 6'h3f;
			prime_q <= 3'h0;
		end else begin
			pin_s1_q <= pin_raw;
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
			prime_q <= {prime_q[1:0], 1'b1};
		end
	end

	// edges are ignored until the chain holds real pin levels,
	// so a pin held low through reset gives no false request
	assign sync_ok = prime_q[2];

	// ----------------------------------------------------------------
	// edge detection
	// ----------------------------------------------------------------
	reg [3:0] esel1_q;
	reg [3:0] esel2_q;
	wire [5:0] pin_edge;

	assign pin_edge[0] = sync_ok & pin_s3_q[0] & ~pin_s2_q[0];
	assign pin_edge[1] = sync_ok & pin_s3_q[1] & ~pin_s2_q[1];
	assign pin_edge[2] = sync_ok &
		edge_hit(esel1_q[1:0], pin_s3_q[2], pin_s2_q[2]);
	assign pin_edge[3] = sync_ok &
		edge_hit(esel1_q[3:2], pin_s3_q[3], pin_s2_q[3]);
	assign pin_edge[4] = sync_ok &
		edge_hit(esel2_q[1:0], pin_s3_q[4], pin_s2_q[4]);
	assign pin_edge[5] = sync_ok &
		edge_hit(esel2_q[3:2], pin_s3_q[5], pin_s2_q[5]);

	// ----------------------------------------------------------------
	// hardware set terms
	// ----------------------------------------------------------------
	wire [10:0] hw_set;

	assign hw_set[`IPC_I_PIN0] = pin_edge[0];
	assign hw_set[`IPC_I_PIN1] = pin_edge[1];
	assign hw_set[`IPC_I_TMRA] = tmr_a_ovf_in;
	assign hw_set[`IPC_I_TMRB] = tmr_b_ovf_in;
	assign hw_set[`IPC_I_PIN2] = pin_edge[2];
	assign hw_set[`IPC_I_TMRC] = tmr_c_ovf_in;
	assign hw_set[`IPC_I_PIN3] = pin_edge[3];
	assign hw_set[`IPC_I_TMRD] = tmr_d_ovf_in |
		(tmr_d_capture_mode_in & pin_edge[5]);
	assign hw_set[`IPC_I_PIN4] = pin_edge[4];
	assign hw_set[`IPC_I_ADC] = converter_done_in;
	assign hw_set[`IPC_I_SER] = serial_done_in;

	// ----------------------------------------------------------------
	// write decode
	// ----------------------------------------------------------------
	reg [10:0] f_clr;
	reg [10:0] m_we;
	reg [10:0] m_val;
	reg ie_we;
	reg [3:0] es1_we;
	reg [3:0] es2_we;

	always @* begin
		f_clr = 11'h000;
		m_we = 11'h000;
		m_val = 11'h000;
		ie_we = 1'b0;
		es1_we = 4'h0;
		es2_we = 4'h0;
		if (wr_en_in) begin
			case (addr_in)
				`IPC_ADR_W0: begin
					ie_we = wr_bits_in[`IPC_IE_BIT];
					f_clr[`IPC_I_PIN0] = sw_clr(wr_bits_in, wr_data_in,
						`IPC_HI_FLAG);
					m_we[`IPC_I_PIN0] = wr_bits_in[`IPC_HI_MASK];
					m_val[`IPC_I_PIN0] = wr_data_in[`IPC_HI_MASK];
				end
				`IPC_ADR_W1: begin
					f_clr[`IPC_I_PIN1] = sw_clr(wr_bits_in, wr_data_in,
						`IPC_LO_FLAG);
					m_we[`IPC_I_PIN1] = wr_bits_in[`IPC_LO_MASK];
					m_val[`IPC_I_PIN1] = wr_data_in[`IPC_LO_MASK];
					f_clr[`IPC_I_TMRA] = sw_clr(wr_bits_in, wr_data_in,
						`IPC_HI_FLAG);
					m_we[`IPC_I_TMRA] = wr_bits_in[`IPC_HI_MASK];
					m_val[`IPC_I_TMRA] = wr_data_in[`IPC_HI_MASK];
				end
				`IPC_ADR_TBC: begin
					f_clr[`IPC_I_TMRB] = sw_clr(wr_bits_in, wr_data_in,
						`IPC_LO_FLAG);
					m_we[`IPC_I_TMRB] = wr_bits_in[`IPC_LO_MASK];
					m_val[`IPC_I_TMRB] = wr_data_in[`IPC_LO_MASK];
					f_clr[`IPC_I_TMRC] = sw_clr(wr_bits_in, wr_data_in,
						`IPC_HI_FLAG);
					m_we[`IPC_I_TMRC] = wr_bits_in[`IPC_HI_MASK];
					m_val[`IPC_I_TMRC] = wr_data_in[`IPC_HI_MASK];
				end
				`IPC_ADR_TDAD: begin
					f_clr[`IPC_I_TMRD] = sw_clr(wr_bits_in, wr_data_in,
						`IPC_LO_FLAG);
					m_we[`IPC_I_TMRD] = wr_bits_in[`IPC_LO_MASK];
					m_val[`IPC_I_TMRD] = wr_data_in[`IPC_LO_MASK];
					f_clr[`IPC_I_ADC] = sw_clr(wr_bits_in, wr_data_in,
						`IPC_HI_FLAG);
					m_we[`IPC_I_ADC] = wr_bits_in[`IPC_HI_MASK];
					m_val[`IPC_I_ADC] = wr_data_in[`IPC_HI_MASK];
				end
				`IPC_ADR_EXHI: begin
					f_clr[`IPC_I_PIN2] = sw_clr(wr_bits_in, wr_data_in,
						`IPC_LO_FLAG);
					m_we[`IPC_I_PIN2] = wr_bits_in[`IPC_LO_MASK];
					m_val[`IPC_I_PIN2] = wr_data_in[`IPC_LO_MASK];
					f_clr[`IPC_I_PIN3] = sw_clr(wr_bits_in, wr_data_in,
						`IPC_HI_FLAG);
					m_we[`IPC_I_PIN3] = wr_bits_in[`IPC_HI_MASK];
					m_val[`IPC_I_PIN3] = wr_data_in[`IPC_HI_MASK];
				end
				`IPC_ADR_SEREX: begin
					f_clr[`IPC_I_PIN4] = sw_clr(wr_bits_in, wr_data_in,
						`IPC_LO_FLAG);
					m_we[`IPC_I_PIN4] = wr_bits_in[`IPC_LO_MASK];
					m_val[`IPC_I_PIN4] = wr_data_in[`IPC_LO_MASK];
					f_clr[`IPC_I_SER] = sw_clr(wr_bits_in, wr_data_in,
						`IPC_HI_FLAG);
					m_we[`IPC_I_SER] = wr_bits_in[`IPC_HI_MASK];
					m_val[`IPC_I_SER] = wr_data_in[`IPC_HI_MASK];
				end
				`IPC_ADR_ESEL1: es1_we = wr_bits_in;
				`IPC_ADR_ESEL2: es2_we = wr_bits_in;
				default: ie_we = 1'b0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// flags, masks, edge select
	// ----------------------------------------------------------------
	reg [10:0] flag_q;
	reg [10:0] mask_q;
	wire [10:0] flag_d;
	wire [10:0] mask_d;

	// a set in the same cycle as a clear wins, so no event is lost;
	// nothing else clears a flag, acknowledge included
	assign flag_d = (flag_q & ~f_clr) | hw_set;
	assign mask_d = (mask_q & ~m_we) | (m_val & m_we);

	always @(posedge clk_in or negedge rst_b) begin
		if (!rst_b) begin
			flag_q <= `IPC_RST_FLAGS;
			mask_q <= `IPC_RST_MASKS;
			esel1_q <= `IPC_RST_ESEL;
			esel2_q <= `IPC_RST_ESEL;
		end else begin
			flag_q <= flag_d;
			mask_q <= mask_d;
			esel1_q <= (esel1_q & ~es1_we) | (wr_data_in & es1_we);
			esel2_q <= (esel2_q & ~es2_we) | (wr_data_in & es2_we);
		end
	end

	// ----------------------------------------------------------------
	// priority pick
	// ----------------------------------------------------------------
	wire [10:0] req;
	wire [7:1] slot_req;
	reg [2:0] slot_d;
	integer k;

	assign req = flag_q & ~mask_q;
	assign slot_req[1] = req[`IPC_I_PIN0];
	assign slot_req[2] = req[`IPC_I_PIN1];
	assign slot_req[3] = req[`IPC_I_TMRA];
	assign slot_req[4] = req[`IPC_I_TMRB] | req[`IPC_I_PIN2];
	assign slot_req[5] = req[`IPC_I_TMRC] | req[`IPC_I_PIN3];
	assign slot_req[6] = req[`IPC_I_TMRD] | req[`IPC_I_PIN4];
	assign slot_req[7] = req[`IPC_I_ADC] | req[`IPC_I_SER];

	// scan from lowest priority up so the highest one lands last
	always @* begin
		slot_d = `IPC_SLOT_NONE;
		for (k = 7; k >= 1; k = k - 1) begin
			if (slot_req[k])
				slot_d = k[2:0];
		end
	end

	// ----------------------------------------------------------------
	// enable and acknowledge sequence
	// ----------------------------------------------------------------
	reg ie_q;
	reg ack_q;

	always @(posedge clk_in or negedge rst_b) begin
		if (!rst_b) begin
			ie_q <= `IPC_RST_IE;
			ack_q <= 1'b0;
		end else begin
			ack_q <= int_ack_in;
			if (ack_q)
				ie_q <= 1'b0;
			else if (return_from_interrupt_in)
				ie_q <= 1'b1;
			else if (ie_we)
				ie_q <= wr_data_in[`IPC_IE_BIT];
		end
	end

	// ----------------------------------------------------------------
	// outputs and read back
	// ----------------------------------------------------------------
	reg [3:0] rd_d;

	always @* begin
		rd_d = 4'h0;
		case (addr_in)
			`IPC_ADR_W0: rd_d = {mask_q[`IPC_I_PIN0], flag_q[`IPC_I_PIN0],
				1'b0, ie_q};
			`IPC_ADR_W1: rd_d = {mask_q[`IPC_I_TMRA], flag_q[`IPC_I_TMRA],
				mask_q[`IPC_I_PIN1], flag_q[`IPC_I_PIN1]};
			`IPC_ADR_TBC: rd_d = {mask_q[`IPC_I_TMRC], flag_q[`IPC_I_TMRC],
				mask_q[`IPC_I_TMRB], flag_q[`IPC_I_TMRB]};
			`IPC_ADR_TDAD: rd_d = {mask_q[`IPC_I_ADC], flag_q[`IPC_I_ADC],
				mask_q[`IPC_I_TMRD], flag_q[`IPC_I_TMRD]};
			`IPC_ADR_EXHI: rd_d = {mask_q[`IPC_I_PIN3], flag_q[`IPC_I_PIN3],
				mask_q[`IPC_I_PIN2], flag_q[`IPC_I_PIN2]};
			`IPC_ADR_SEREX: rd_d = {mask_q[`IPC_I_SER], flag_q[`IPC_I_SER],
				mask_q[`IPC_I_PIN4], flag_q[`IPC_I_PIN4]};
			// edge select registers are write-only and read zero
			default: rd_d = 4'h0;
		endcase
	end

	always @(posedge clk_in or negedge rst_b) begin
		if (!rst_b) begin
			rd_data_out <= 4'h0;
			int_req_out <= 1'b0;
			int_slot_out <= `IPC_SLOT_NONE;
			global_int_enable_out <= 1'b0;
			timer_d_event_edge_out <= 1'b0;
		end else begin
			if (rd_en_in)
				rd_data_out <= rd_d;
			// request drops while an acknowledge is in flight
			int_req_out <= ie_q & (|slot_req) & ~int_ack_in
				& ~ack_q;
			int_slot_out <= slot_d;
			global_int_enable_out <= ie_q;
			timer_d_event_edge_out <= pin_edge[5];
		end
	end

endmodule // ipc_top

// ---- tb/ipc_monitor.sv ----
// port assertions for the interrupt priority control
`timescale 1ns/1ps
module ipc_monitor #(
	parameter ADDR_W = 10
) (
	input wire clk_in,
	input wire rst_b_in,
	input wire [ADDR_W-1:0] addr_in,
	input wire wr_en_in,
	input wire rd_en_in,
	input wire [3:0] rd_data_out,
	input wire int_ack_in,
	input wire return_from_interrupt_in,
	input wire int_req_out,
	input wire [2:0] int_slot_out,
	input wire global_int_enable_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_b_in);
	// ack, then three cycles with nothing that could set enable again
	sequence ack_quiet;
		int_ack_in ##1 (!return_from_interrupt_in && !wr_en_in)[*3];
	endsequence
	sequence ret_alone;
		return_from_interrupt_in && !int_ack_in && !$past(int_ack_in);
	endsequence
	slot_on_req_a: assert property (
		int_req_out |-> int_slot_out != 3'h0)
		else $error("request without a slot");
	ack_drops_req_a: assert property (
		int_ack_in |-> ##2 !int_req_out ##1 !int_req_out)
		else $error("request stayed after ack");
	ack_clears_en_a: assert property (
		ack_quiet |=> !global_int_enable_out)
		else $error("enable stayed after ack");
	ret_sets_en_a: assert property (
		ret_alone |-> ##[2:3] global_int_enable_out)
		else $error("enable not set by return");
	no_en_idle_a: assert property (
		!global_int_enable_out[*3] |-> !int_req_out)
		else $error("request while disabled");
	req_holds_a: assert property (
		int_req_out && !int_ack_in && !$past(int_ack_in) && !wr_en_in
		&& !$past(wr_en_in) |=> int_req_out)
		else $error("request vanished on its own");
	rst_state_a: assert property (
		$rose(rst_b_in) |-> (!int_req_out && !global_int_enable_out
		&& int_slot_out == 3'h0)[*2])
		else $error("wrong state after reset");
	wo_read_zero_a: assert property (
		rd_en_in && (addr_in == 10'h026 || addr_in == 10'h027)
		|=> rd_data_out == 4'h0)
		else $error("write-only register read nonzero");
endmodule // ipc_monitor

// ---- tb/ipc_seq_model.sv ----
// cpu sequencer model: acknowledges requests, returns on command
`timescale 1ns/1ps
module ipc_seq_model (
	input wire clk_in,
	input wire int_req_in,
	input wire on_in,
	input wire slow_in,
	input wire ret_go_in,
	output reg int_ack_out,
	output reg ret_out
);
	reg [1:0] wait_q = 2'h0;
	reg busy_q = 1'b0;
	initial int_ack_out = 1'b0;
	initial ret_out = 1'b0;
	// one ack per request; slow mode waits so the level is seen holding
	always @(posedge clk_in) begin
		int_ack_out <= 1'b0;
		ret_out <= ret_go_in & busy_q;
		if (ret_go_in)
			busy_q <= 1'b0;
		else if (on_in && int_req_in && !busy_q) begin
			if (wait_q == (slow_in ? 2'h3 : 2'h0)) begin
				int_ack_out <= 1'b1;
				busy_q <= 1'b1;
				wait_q <= 2'h0;
			end else
				wait_q <= wait_q + 2'h1;
		end
	end
endmodule // ipc_seq_model

// ---- tb/ipc_tb_top.sv ----
// self-checking bench for the interrupt priority control
`timescale 1ns/1ps
module ipc_tb_top;
	typedef struct packed {logic [9:0] a; logic [5:0] e; logic [3:0] m;
		logic [3:0] v; logic [2:0] s;} ipc_row_t;
	reg clk_in = 1'b0;
	reg rst_b_in = 1'b0;
	reg [9:0] adr = 10'h000;
	reg we = 1'b0;
	reg re = 1'b0;
	reg [3:0] wb = 4'h0;
	reg [3:0] wd = 4'h0;
	reg [4:0] pin = 5'h03;
	reg evp = 1'b0;
	reg cap = 1'b0;
	reg [5:0] ev = 6'h00;
	reg on = 1'b0;
	reg slow = 1'b0;
	reg ret_go = 1'b0;
	wire [3:0] rdat;
	wire ack;
	wire ret;
	wire req;
	wire [2:0] slot;
	wire ien;
	wire evo;
	reg evs = 1'b0;
	integer mismatches = 0;
	integer n_checks = 0;
	integer i;
	ipc_row_t r;
	ipc_row_t rows [0:5] = '{
		'{10'h001, 6'h01, 4'h8, 4'h6, 3'h3},
		'{10'h002, 6'h02, 4'h2, 4'h9, 3'h4},
		'{10'h002, 6'h04, 4'h8, 4'h6, 3'h5},
		'{10'h003, 6'h08, 4'h2, 4'h9, 3'h6},
		'{10'h003, 6'h20, 4'h8, 4'h6, 3'h7},
		'{10'h023, 6'h10, 4'h8, 4'h6, 3'h7}};
	always #10 clk_in = ~clk_in;
	ipc_top ipc_top_inst (.clk_in(clk_in), .rst_b_in(rst_b_in),
		.addr_in(adr), .wr_en_in(we), .wr_bits_in(wb),
		.wr_data_in(wd), .rd_en_in(re), .rd_data_out(rdat),
		.ext_irq_pin_zero_b_in(pin[0]), .ext_irq_pin_one_b_in(pin[1]),
		.ext_irq_pin_two_in(pin[2]), .ext_irq_pin_three_in(pin[3]),
		.ext_irq_pin_four_in(pin[4]), .timer_d_event_pin_in(evp),
		.tmr_d_capture_mode_in(cap), .tmr_a_ovf_in(ev[0]),
		.tmr_b_ovf_in(ev[1]), .tmr_c_ovf_in(ev[2]),
		.tmr_d_ovf_in(ev[3]), .serial_done_in(ev[4]),
		.converter_done_in(ev[5]), .int_ack_in(ack),
		.return_from_interrupt_in(ret), .int_req_out(req),
		.int_slot_out(slot), .global_int_enable_out(ien),
		.timer_d_event_edge_out(evo));
	// sticky copy of the one-cycle event edge pulse
	always @(posedge clk_in) evs <= evs | evo;
	ipc_seq_model ipc_seq_model_inst (.clk_in(clk_in),
		.int_req_in(req), .on_in(on), .slow_in(slow),
		.ret_go_in(ret_go), .int_ack_out(ack), .ret_out(ret));
	// ------------------------------------------------
	// bus and compare tasks
	// ------------------------------------------------
	task chk(input logic [3:0] got, input logic [3:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: %h, expected %h", $time, got, exp);
		end
	endtask
	task idle(input int n);
		repeat (n) @(negedge clk_in);
	endtask
	task wr(input logic [9:0] a, input logic [3:0] b, input logic [3:0] d);
		@(negedge clk_in);
		adr = a;
		wb = b;
		wd = d;
		we = 1'b1;
		@(negedge clk_in);
		we = 1'b0;
	endtask
	// spare cycles first so a preceding write or pin edge has landed
	task rdc(input logic [9:0] a, input logic [3:0] exp);
		idle(3);
		adr = a;
		re = 1'b1;
		@(negedge clk_in);
		re = 1'b0;
		chk(rdat, exp);
	endtask
	task pulse(input logic [5:0] m);
		@(negedge clk_in);
		ev = m;
		@(negedge clk_in);
		ev = 6'h00;
		idle(2);
	endtask
	task retn;
		@(negedge clk_in);
		ret_go = 1'b1;
		@(negedge clk_in);
		ret_go = 1'b0;
	endtask
	task wrap_up;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		#100000;
		mismatches++;
		wrap_up;
	end
	initial begin
		idle(2);
		rst_b_in = 1'b1;
		idle(4);
		rdc(10'h000, 4'h8);
		rdc(10'h001, 4'ha);
		rdc(10'h026, 4'h0);
		rdc(10'h010, 4'h0);
		for (i = 0; i < 6; i++) begin
			r = rows[i];
			wr(r.a, r.m, 4'h0);
			pulse(r.e);
			chk({1'b0, slot}, {1'b0, r.s});
			chk({3'h0, req}, 4'h0);
			rdc(r.a, r.v);
			wr(r.a, r.m | (r.m >> 1), r.m);
			idle(2);
			chk({1'b0, slot}, 4'h0);
		end
		wr(10'h002, 4'h1, 4'h1);
		rdc(10'h002, 4'ha);
		wr(10'h001, 4'h8, 4'h0);
		wr(10'h002, 4'h8, 4'h0);
		pulse(6'h05);
		chk({1'b0, slot}, 4'h3);
		wr(10'h001, 4'h4, 4'h0);
		idle(2);
		chk({1'b0, slot}, 4'h5);
		wr(10'h002, 4'h8, 4'h8);
		rdc(10'h002, 4'he);
		chk({1'b0, slot}, 4'h0);
		wr(10'h002, 4'h4, 4'h0);
		on = 1'b1;
		wr(10'h000, 4'h1, 4'h1);
		pulse(6'h01);
		idle(6);
		chk({3'h0, ien}, 4'h0);
		rdc(10'h001, 4'h6);
		slow = 1'b1;
		retn;
		idle(3);
		chk({3'h0, ien}, 4'h1);
		chk({3'h0, req}, 4'h1);
		idle(8);
		chk({3'h0, req}, 4'h0);
		wr(10'h001, 4'h4, 4'h0);
		retn;
		idle(3);
		chk({3'h0, req}, 4'h0);
		on = 1'b0;
		wr(10'h000, 4'h1, 4'h0);
		for (i = 0; i < 4; i++) begin
			wr(10'h026, 4'h3, i[3:0]);
			pin[2] = 1'b1;
			rdc(10'h022, {3'h5, i[1]});
			wr(10'h022, 4'h1, 4'h0);
			pin[2] = 1'b0;
			rdc(10'h022, {3'h5, i[0]});
			wr(10'h022, 4'h1, 4'h0);
		end
		wr(10'h000, 4'h8, 4'h0);
		pin[0] = 1'b0;
		idle(5);
		chk({1'b0, slot}, 4'h1);
		wr(10'h000, 4'h4, 4'h0);
		pin[0] = 1'b1;
		idle(5);
		chk({1'b0, slot}, 4'h0);
		wr(10'h027, 4'hf, 4'hb);
		chk({3'h0, evs}, 4'h0);
		cap = 1'b1;
		evp = 1'b1;
		pin[4] = 1'b1;
		rdc(10'h003, 4'hb);
		rdc(10'h023, 4'hb);
		chk({3'h0, evs}, 4'h1);
		rst_b_in = 1'b0;
		idle(2);
		rst_b_in = 1'b1;
		idle(4);
		rdc(10'h000, 4'h8);
		rdc(10'h023, 4'ha);
		wrap_up;
	end
endmodule // ipc_tb_top

bind ipc_top ipc_monitor #(.ADDR_W(ADDR_W)) ipc_monitor_inst (
	.clk_in(clk_in), .rst_b_in(rst_b_in), .addr_in(addr_in),
	.wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
	.rd_data_out(rd_data_out), .int_ack_in(int_ack_in),
	.return_from_interrupt_in(return_from_interrupt_in),
	.int_req_out(int_req_out), .int_slot_out(int_slot_out),
	.global_int_enable_out(global_int_enable_out));
